// ### hw/utsc_pkg.sv
// constants and types shared by both ends of the transceiver link
package utsc_pkg;
   localparam logic [31:0] UTSC_CLK_HZ = 32'd25000000;
   // control register offsets over axi4-lite
   localparam logic [3:0] UTSC_OFS_CR0 = 4'h0;
   localparam logic [3:0] UTSC_OFS_CR1 = 4'h4;
   localparam logic [3:0] UTSC_OFS_IO0 = 4'h8;
   localparam logic [3:0] UTSC_OFS_IO1 = 4'hc;
   // usb_control_reg_0 fields
   localparam int UTSC_CR0_ENABLE = 7;
   // usb_control_reg_1 fields
   localparam int UTSC_CR1_REGSEL = 0;
   localparam int UTSC_CR1_LOCK = 1;
   localparam int UTSC_CR1_ACTIVITY = 2;
   // pin_io_control_0 fields
   localparam int UTSC_IO0_TEN = 7;
   localparam int UTSC_IO0_SE0 = 6;
   localparam int UTSC_IO0_LEVEL = 5;
   localparam int UTSC_IO0_RD = 0;
   // pin_io_control_1 fields
   localparam int UTSC_IO1_BITBANG = 7;
   localparam int UTSC_IO1_CMOS = 6;
   localparam int UTSC_IO1_DPI = 5;
   localparam int UTSC_IO1_DMI = 4;
   localparam int UTSC_IO1_LEGACY = 3;
   localparam int UTSC_IO1_DPPU = 2;
   localparam int UTSC_IO1_DPO = 1;
   localparam int UTSC_IO1_DMO = 0;
   localparam logic [7:0] UTSC_RST_CR0 = 8'h00;
   localparam logic [7:0] UTSC_RST_CR1 = 8'h00;
   localparam logic [7:0] UTSC_RST_IO0 = 8'h00;
   localparam logic [7:0] UTSC_RST_IO1 = 8'h00;
   // axi responses
   localparam logic [1:0] UTSC_RESP_OKAY = 2'b00;
   localparam logic [1:0] UTSC_RESP_SLVERR = 2'b10;
   // lock trim tolerance in parts per ten thousand (0.25 %)
   localparam int UTSC_LOCK_TOL_PPTT = 25;
   // resume k time window
   localparam int UTSC_RESUME_MIN_MS = 1;
   localparam int UTSC_RESUME_MAX_MS = 15;
   localparam int UTSC_CYC_PER_MS = 25000;
   localparam logic [19:0] UTSC_RESUME_K_MS = 20'd2;
   localparam logic [19:0] UTSC_CYC_PER_MS_W = 20'd25000;
   localparam logic [7:0] UTSC_J_CYCLES = 8'd1;
   // trim register reset value
   localparam logic [7:0] UTSC_RST_TRIM = 8'h80;
   localparam logic [7:0] UTSC_RST_EP = 8'h00;
   // sleep kinds
   typedef enum logic [1:0] {
      UTSC_SLEEP_NONE,
      UTSC_SLEEP_RETAIN,
      UTSC_SLEEP_STANDBY,
      UTSC_SLEEP_DEEP
   } utsc_sleep_e;
endpackage

// ### hw/utsc_link_if.sv
// d+/d- link between device transceiver and host or hub
interface utsc_link_if;
   logic dp_dev_o;
   logic dp_dev_oe;
   logic dm_dev_o;
   logic dm_dev_oe;
   logic dp_pu15;
   logic dp_pu5;
   logic dm_pu5;
   logic dp_host_o;
   logic dp_host_oe;
   logic dm_host_o;
   logic dm_host_oe;
   logic dp;
   logic dm;
   // resolved line level: drivers win, then pull-ups, else low
   assign dp = dp_dev_oe ? dp_dev_o :
               dp_host_oe ? dp_host_o : (dp_pu15 | dp_pu5);
   assign dm = dm_dev_oe ? dm_dev_o :
               dm_host_oe ? dm_host_o : dm_pu5;
   modport device (
      output dp_dev_o, dp_dev_oe, dm_dev_o, dm_dev_oe,
      output dp_pu15, dp_pu5, dm_pu5,
      input dp, dm
   );
   modport host (
      output dp_host_o, dp_host_oe, dm_host_o, dm_host_oe,
      input dp, dm
   );
endinterface

// ### hw/utsc_device.sv
// device end: transceiver control, pull-ups, activity, sleep and wake
module utsc_device
   import utsc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_b,
   utsc_link_if.device link,
   // axi4-lite slave
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [3:0] s_awaddr,
   input wire logic s_wvalid,
   output logic s_wready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   output logic s_bvalid,
   input wire logic s_bready,
   output logic [1:0] s_bresp,
   input wire logic s_arvalid,
   output logic s_arready,
   input wire logic [3:0] s_araddr,
   output logic s_rvalid,
   input wire logic s_rready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   // serial interface engine side
   input wire logic sie_oe,
   input wire logic sie_dp,
   input wire logic sie_dm,
   output logic sie_rx_enable,
   output logic sie_rd,
   // oscillator, regulator and receiver power
   output logic osc_lock_enable,
   output logic regulator_select,
   output logic regulator_low_power,
   output logic rx_power_down,
   // sleep control
   input wire logic sleep_req,
   input wire utsc_sleep_e sleep_kind,
   input wire logic wake_int_enable,
   output logic asleep,
   output logic bus_wake_int,
   output logic ep_regs_reset
);
   typedef struct packed {
      logic [7:0] cr0;
      logic [7:0] cr1;
      logic [7:0] io0;
      logic [7:0] io1;
      logic [2:0] dp_sync;
      logic [2:0] dm_sync;
      logic aw_got;
      logic w_got;
      logic [3:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic asleep;
      utsc_sleep_e kind;
      logic wake_int;
      logic ep_rst;
      logic dp_o;
      logic dp_oe;
      logic dm_o;
      logic dm_oe;
      logic pu15;
      logic pu5;
      logic dp_lvl;
      logic dm_lvl;
      logic rd;
      logic rx_pd;
      logic aw_rdy;
      logic w_rdy;
      logic ar_rdy;
   } utsc_dev_s;
   utsc_dev_s st_ff;
   utsc_dev_s nxt_st;
   logic dp_s;
   logic dm_s;
   logic activity;
   logic do_wr;
   logic [7:0] wbyte;
   always_comb
   begin
      nxt_st = st_ff;
      dp_s = st_ff.dp_lvl;
      dm_s = st_ff.dm_lvl;
      // a change counts once stages two and three agree
      activity = (st_ff.dp_sync[1] == st_ff.dp_sync[2] &&
                  st_ff.dp_sync[2] != st_ff.dp_lvl) ||
                 (st_ff.dm_sync[1] == st_ff.dm_sync[2] &&
                  st_ff.dm_sync[2] != st_ff.dm_lvl);
      if (st_ff.dp_sync[1] == st_ff.dp_sync[2])
         nxt_st.dp_lvl = st_ff.dp_sync[2];
      if (st_ff.dm_sync[1] == st_ff.dm_sync[2])
         nxt_st.dm_lvl = st_ff.dm_sync[2];
      nxt_st.dp_sync = {st_ff.dp_sync[1:0], link.dp};
      nxt_st.dm_sync = {st_ff.dm_sync[1:0], link.dm};
      nxt_st.ep_rst = 1'b0;
      // axi write channels taken in either order
      if (s_awvalid && !st_ff.aw_got)
      begin
         nxt_st.aw_got = 1'b1;
         nxt_st.awaddr = s_awaddr;
      end
      if (s_wvalid && !st_ff.w_got)
      begin
         nxt_st.w_got = 1'b1;
         nxt_st.wdata = s_wdata;
         nxt_st.wstrb = s_wstrb;
      end
      do_wr = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
      wbyte = st_ff.wdata[7:0];
      // hardware-set activity beats a firmware clear
      if (do_wr)
      begin
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp = UTSC_RESP_OKAY;
         if (st_ff.wstrb[0])
         begin
            case (st_ff.awaddr)
               UTSC_OFS_CR0: nxt_st.cr0 = wbyte;
               UTSC_OFS_CR1:
               begin
                  nxt_st.cr1[UTSC_CR1_REGSEL] = wbyte[UTSC_CR1_REGSEL];
                  nxt_st.cr1[UTSC_CR1_LOCK] = wbyte[UTSC_CR1_LOCK];
                  if (!wbyte[UTSC_CR1_ACTIVITY])
                     nxt_st.cr1[UTSC_CR1_ACTIVITY] = 1'b0;
               end
               UTSC_OFS_IO0: nxt_st.io0 = {wbyte[7:5], 5'h00};
               UTSC_OFS_IO1: nxt_st.io1 = {wbyte[7:2], 2'b00};
               default: nxt_st.bresp = UTSC_RESP_SLVERR;
            endcase
         end
      end
      if (activity)
         nxt_st.cr1[UTSC_CR1_ACTIVITY] = 1'b1;
      if (st_ff.bvalid && s_bready)
      begin
         nxt_st.bvalid = 1'b0;
         nxt_st.aw_got = 1'b0;
         nxt_st.w_got = 1'b0;
      end
      // read channel; pin levels readable in any mode
      if (s_arvalid && !st_ff.rvalid)
      begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rresp = UTSC_RESP_OKAY;
         nxt_st.rdata = 32'h00000000;
         case (s_araddr)
            UTSC_OFS_CR0: nxt_st.rdata[7:0] = st_ff.cr0;
            UTSC_OFS_CR1: nxt_st.rdata[7:0] = st_ff.cr1;
            UTSC_OFS_IO0: nxt_st.rdata[7:0] =
               {st_ff.io0[7:1], dp_s & ~dm_s};
            UTSC_OFS_IO1: nxt_st.rdata[7:0] =
               {st_ff.io1[7:2], dp_s, dm_s};
            default: nxt_st.rresp = UTSC_RESP_SLVERR;
         endcase
      end
      else if (st_ff.rvalid && s_rready)
         nxt_st.rvalid = 1'b0;
      // sleep entry; config registers never cleared here
      if (!st_ff.asleep && sleep_req && sleep_kind != UTSC_SLEEP_NONE)
      begin
         nxt_st.asleep = 1'b1;
         nxt_st.kind = sleep_kind;
      end
      nxt_st.wake_int = 1'b0;
      // wake only while asleep and enabled; d+ low wakes at once
      if (st_ff.asleep && wake_int_enable && (activity || !dp_s))
      begin
         nxt_st.wake_int = 1'b1;
         nxt_st.asleep = 1'b0;
         if (st_ff.kind == UTSC_SLEEP_STANDBY ||
             st_ff.kind == UTSC_SLEEP_DEEP)
            nxt_st.ep_rst = 1'b1;
      end
      // pin drive: bitbang, then manual, then engine
      nxt_st.dp_oe = 1'b0;
      nxt_st.dm_oe = 1'b0;
      nxt_st.dp_o = 1'b0;
      nxt_st.dm_o = 1'b0;
      if (st_ff.io1[UTSC_IO1_BITBANG])
      begin
         nxt_st.dp_o = st_ff.io1[UTSC_IO1_DPI];
         nxt_st.dm_o = st_ff.io1[UTSC_IO1_DMI];
         nxt_st.dp_oe = st_ff.io1[UTSC_IO1_CMOS] | ~st_ff.io1[UTSC_IO1_DPI];
         nxt_st.dm_oe = st_ff.io1[UTSC_IO1_CMOS] | ~st_ff.io1[UTSC_IO1_DMI];
      end
      else if (st_ff.io0[UTSC_IO0_TEN])
      begin
         nxt_st.dp_oe = 1'b1;
         nxt_st.dm_oe = 1'b1;
         if (!st_ff.io0[UTSC_IO0_SE0])
         begin
            nxt_st.dp_o = st_ff.io0[UTSC_IO0_LEVEL];
            nxt_st.dm_o = ~st_ff.io0[UTSC_IO0_LEVEL];
         end
      end
      else if (st_ff.cr0[UTSC_CR0_ENABLE] && sie_oe)
      begin
         nxt_st.dp_oe = 1'b1;
         nxt_st.dm_oe = 1'b1;
         nxt_st.dp_o = sie_dp;
         nxt_st.dm_o = sie_dm;
      end
      nxt_st.pu15 = st_ff.io1[UTSC_IO1_DPPU];
      nxt_st.pu5 = st_ff.io1[UTSC_IO1_LEGACY];
      // registered copies so outputs leave flops
      nxt_st.rd = nxt_st.dp_lvl & ~nxt_st.dm_lvl;
      nxt_st.rx_pd = ~nxt_st.cr0[UTSC_CR0_ENABLE];
      nxt_st.aw_rdy = ~nxt_st.aw_got;
      nxt_st.w_rdy = ~nxt_st.w_got;
      nxt_st.ar_rdy = ~nxt_st.rvalid;
   end
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         st_ff <= '0; // pins tristated, pass-through regulator
         st_ff.cr0 <= UTSC_RST_CR0;
         st_ff.cr1 <= UTSC_RST_CR1;
         st_ff.io0 <= UTSC_RST_IO0;
         st_ff.io1 <= UTSC_RST_IO1;
         st_ff.kind <= UTSC_SLEEP_NONE;
         st_ff.rx_pd <= 1'b1;
         st_ff.aw_rdy <= 1'b1;
         st_ff.w_rdy <= 1'b1;
         st_ff.ar_rdy <= 1'b1;
      end
      else
         st_ff <= nxt_st;
   end
   assign s_awready = st_ff.aw_rdy;
   assign s_wready = st_ff.w_rdy;
   assign s_bvalid = st_ff.bvalid;
   assign s_bresp = st_ff.bresp;
   assign s_arready = st_ff.ar_rdy;
   assign s_rvalid = st_ff.rvalid;
   assign s_rdata = st_ff.rdata;
   assign s_rresp = st_ff.rresp;
   assign sie_rx_enable = st_ff.cr0[UTSC_CR0_ENABLE];
   assign sie_rd = st_ff.rd;
   assign osc_lock_enable = st_ff.cr1[UTSC_CR1_LOCK];
   assign regulator_select = st_ff.cr1[UTSC_CR1_REGSEL];
   assign regulator_low_power = st_ff.asleep;
   assign rx_power_down = st_ff.rx_pd;
   assign asleep = st_ff.asleep;
   assign bus_wake_int = st_ff.wake_int;
   assign ep_regs_reset = st_ff.ep_rst;
   assign link.dp_dev_o = st_ff.dp_o;
   assign link.dp_dev_oe = st_ff.dp_oe;
   assign link.dm_dev_o = st_ff.dm_o;
   assign link.dm_dev_oe = st_ff.dm_oe;
   assign link.dp_pu15 = st_ff.pu15;
   assign link.dp_pu5 = st_ff.pu5;
   assign link.dm_pu5 = st_ff.pu5;
endmodule

// ### hw/utsc_host.sv
// host end: drives j, k, se0 or idle onto the link and samples it
module utsc_host
   import utsc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_b,
   utsc_link_if.host link,
   input wire logic drive_en,
   input wire logic drive_se0,
   input wire logic drive_level,
   output logic line_dp,
   output logic line_dm,
   output logic attached,
   output logic resume_seen
);
   typedef struct packed {
      logic dp_o;
      logic dm_o;
      logic oe;
      logic [2:0] dp_sync;
      logic [2:0] dm_sync;
      logic line_dp;
      logic line_dm;
      logic attached;
      logic resume;
      logic [19:0] k_cnt;
   } utsc_host_s;
   utsc_host_s st_ff;
   utsc_host_s nxt_st;
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.dp_sync = {st_ff.dp_sync[1:0], link.dp};
      nxt_st.dm_sync = {st_ff.dm_sync[1:0], link.dm};
      nxt_st.oe = drive_en;
      nxt_st.dp_o = drive_en & ~drive_se0 & drive_level;
      nxt_st.dm_o = drive_en & ~drive_se0 & ~drive_level;
      if (st_ff.dp_sync[1] == st_ff.dp_sync[2])
         nxt_st.line_dp = st_ff.dp_sync[2];
      if (st_ff.dm_sync[1] == st_ff.dm_sync[2])
         nxt_st.line_dm = st_ff.dm_sync[2];
      nxt_st.attached = st_ff.line_dp & ~st_ff.line_dm;
      // k held by the device for at least 1 ms counts as resume
      if (!st_ff.oe && !st_ff.line_dp && st_ff.line_dm)
      begin
         if (st_ff.k_cnt != UTSC_CYC_PER_MS_W)
            nxt_st.k_cnt = st_ff.k_cnt + 20'd1;
         else
            nxt_st.resume = 1'b1;
      end
      else
      begin
         nxt_st.k_cnt = 20'd0;
         nxt_st.resume = 1'b0;
      end
   end
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end
   assign link.dp_host_o = st_ff.dp_o;
   assign link.dm_host_o = st_ff.dm_o;
   assign link.dp_host_oe = st_ff.oe;
   assign link.dm_host_oe = st_ff.oe;
   assign line_dp = st_ff.line_dp;
   assign line_dm = st_ff.line_dm;
   assign attached = st_ff.attached;
   assign resume_seen = st_ff.resume;
endmodule

// ### tb/utsc_asserts.sv
// concurrent checks on the link and the device status outputs
module utsc_asserts
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic dp_dev_oe,
   input wire logic dm_dev_oe,
   input wire logic dp_pu15,
   input wire logic dp_pu5,
   input wire logic dm_pu5,
   input wire logic dp,
   input wire logic dm,
   input wire logic sie_rx_enable,
   input wire logic rx_power_down,
   input wire logic sie_rd,
   input wire logic asleep,
   input wire logic regulator_low_power,
   input wire logic bus_wake_int,
   input wire logic ep_regs_reset
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);
   a_reset_quiet: assert property (
      $rose(rst_b) |-> !(dp_pu15 | dp_pu5 | dm_pu5 | dp_dev_oe | dm_dev_oe))
      else $error("link busy after reset");
   a_legacy_pair: assert property (dp_pu5 == dm_pu5)
      else $error("legacy pull-ups differ");
   a_rx_powered: assert property (sie_rx_enable |-> !rx_power_down)
      else $error("receiver down while enabled");
   a_sleep_lowpow: assert property (
      asleep [*2] |-> regulator_low_power)
      else $error("regulator not in low power");
   a_wake_asleep: assert property (bus_wake_int |-> $past(asleep))
      else $error("wake while awake");
   a_wake_pulse: assert property (bus_wake_int |=> !bus_wake_int)
      else $error("wake longer than a cycle");
   a_ep_after_wake: assert property (
      ep_regs_reset |-> !asleep && ($past(asleep) || $past(asleep, 2)))
      else $error("endpoint reset outside wake");
   a_rx_diff_high: assert property (
      (sie_rx_enable && dp && !dm) [*6] |-> sie_rd)
      else $error("receiver misses j");
   a_rx_diff_low: assert property ((!dp || dm) [*6] |-> !sie_rd)
      else $error("receiver sees j falsely");
   c_wake: cover property (bus_wake_int);
   c_ep_reset: cover property (ep_regs_reset);
   c_manual_k: cover property (dp_dev_oe && !dp && dm);
endmodule

// ### tb/test_usb_transceiver_suspend_control.sv
// bench joining device and host ends across the link
module test_usb_transceiver_suspend_control
   import utsc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
   logic s_arvalid = 1'b0, s_rready = 1'b0;
   logic [3:0] s_awaddr = 4'h0, s_araddr = 4'h0, s_wstrb = 4'hf;
   logic [31:0] s_wdata = 32'h0;
   logic sie_oe = 1'b0, sie_dp = 1'b0, sie_dm = 1'b0;
   logic sleep_req = 1'b0, wake_int_enable = 1'b0;
   utsc_sleep_e sleep_kind = UTSC_SLEEP_NONE;
   logic drive_en = 1'b0, drive_se0 = 1'b0, drive_level = 1'b0;
   logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
   logic [1:0] s_bresp, s_rresp;
   logic [31:0] s_rdata;
   logic sie_rx_enable, sie_rd, osc_lock_enable, regulator_select;
   logic regulator_low_power, rx_power_down, asleep, bus_wake_int;
   logic ep_regs_reset, line_dp, line_dm, attached, resume_seen;
   int error_cnt = 0, checks = 0, cyc = 0, wakes = 0, eprs = 0;
   utsc_link_if link();
   utsc_device u_utsc_device (.clk_sys, .rst_b, .link(link), .s_awvalid,
      .s_awready, .s_awaddr, .s_wvalid, .s_wready, .s_wdata, .s_wstrb,
      .s_bvalid, .s_bready, .s_bresp, .s_arvalid, .s_arready, .s_araddr,
      .s_rvalid, .s_rready, .s_rdata, .s_rresp, .sie_oe, .sie_dp, .sie_dm,
      .sie_rx_enable, .sie_rd, .osc_lock_enable, .regulator_select,
      .regulator_low_power, .rx_power_down, .sleep_req, .sleep_kind,
      .wake_int_enable, .asleep, .bus_wake_int, .ep_regs_reset);
   utsc_host u_utsc_host (.clk_sys, .rst_b, .link(link), .drive_en,
      .drive_se0, .drive_level, .line_dp, .line_dm, .attached, .resume_seen);
   utsc_asserts u_utsc_asserts (.clk_sys, .rst_b,
      .dp_dev_oe(link.dp_dev_oe), .dm_dev_oe(link.dm_dev_oe),
      .dp_pu15(link.dp_pu15), .dp_pu5(link.dp_pu5), .dm_pu5(link.dm_pu5),
      .dp(link.dp), .dm(link.dm), .sie_rx_enable, .rx_power_down, .sie_rd,
      .asleep, .regulator_low_power, .bus_wake_int, .ep_regs_reset);
   always #20 clk_sys = ~clk_sys;
   task automatic end_of_test();
      if (error_cnt == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   always @(posedge clk_sys)
   begin
      cyc++;
      if (bus_wake_int === 1'b1) wakes++;
      if (ep_regs_reset === 1'b1) eprs++;
      if (cyc == 60000)
      begin
         error_cnt++;
         $display("ERROR %0t: timeout", $time);
         end_of_test();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge clk_sys);
      s_awaddr <= a;
      s_wdata <= {24'h0, d};
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      s_bready <= 1'b1;
      while (!(aw_ok && w_ok))
      begin
         @(posedge clk_sys);
         aw_ok = aw_ok | s_awready;
         w_ok = w_ok | s_wready;
         s_awvalid <= !aw_ok;
         s_wvalid <= !w_ok;
      end
      while (s_bvalid !== 1'b1) @(posedge clk_sys);
      s_bready <= 1'b0;
      chk(s_bresp, UTSC_RESP_OKAY);
      repeat (2) @(posedge clk_sys);
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e,
      input logic [1:0] er);
      @(posedge clk_sys);
      s_araddr <= a;
      s_arvalid <= 1'b1;
      s_rready <= 1'b1;
      do @(posedge clk_sys); while (s_arready !== 1'b1);
      s_arvalid <= 1'b0;
      while (s_rvalid !== 1'b1) @(posedge clk_sys);
      s_rready <= 1'b0;
      chk(s_rdata, {24'h0, e});
      chk(s_rresp, er);
   endtask
   // host pulls k onto the bus, or se0 while drive_se0 is set, or lets go
   task automatic host(input logic en, input int n);
      drive_en <= en;
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic nap(input utsc_sleep_e k);
      @(posedge clk_sys);
      sleep_kind <= k;
      sleep_req <= 1'b1;
      @(posedge clk_sys);
      sleep_req <= 1'b0;
      repeat (3) @(posedge clk_sys);
   endtask
   task automatic t_reset();
      chk({regulator_select, osc_lock_enable, link.dp_pu15}, 3'h0);
      rd(UTSC_OFS_CR1, 8'h00, UTSC_RESP_OKAY);
      rd(UTSC_OFS_IO1, 8'h00, UTSC_RESP_OKAY);
      rd(4'h2, 8'h00, UTSC_RESP_SLVERR);
   endtask
   task automatic t_ctrl();
      wr(UTSC_OFS_CR1, 8'h03);
      chk({regulator_select, osc_lock_enable}, 2'h3);
      wr(UTSC_OFS_CR0, 8'h80);
      chk({sie_rx_enable, rx_power_down}, 2'h2);
      wr(UTSC_OFS_IO1, 8'h0c); // bitbang select kept clear
      repeat (6) @(posedge clk_sys);
      rd(UTSC_OFS_IO1, 8'h0f, UTSC_RESP_OKAY);
      wr(UTSC_OFS_IO1, 8'h04);
      repeat (6) @(posedge clk_sys);
      chk({link.dp_pu15, link.dp_pu5, attached, line_dp, line_dm}, 5'h16);
      rd(UTSC_OFS_IO1, 8'h06, UTSC_RESP_OKAY);
      wr(UTSC_OFS_IO1, 8'hd4); // bitbang, cmos, d+ low, d- high
      repeat (4) @(posedge clk_sys);
      chk({link.dp, link.dm}, 2'h1);
      rd(UTSC_OFS_IO1, 8'hd5, UTSC_RESP_OKAY);
      wr(UTSC_OFS_IO1, 8'h04);
   endtask
   task automatic t_manual();
      sie_oe <= 1'b1;
      sie_dm <= 1'b1;
      repeat (4) @(posedge clk_sys);
      chk({link.dp, link.dm}, 2'h1);
      wr(UTSC_OFS_IO0, 8'ha0);
      chk({link.dp, link.dm}, 2'h2);
      repeat (2) @(posedge clk_sys);
      rd(UTSC_OFS_IO0, 8'ha1, UTSC_RESP_OKAY);
      wr(UTSC_OFS_IO0, 8'h80);
      repeat (26000) @(posedge clk_sys);
      chk({resume_seen, link.dp, link.dm}, 3'h5);
      sie_dp <= 1'b1;
      sie_dm <= 1'b0;
      wr(UTSC_OFS_IO0, 8'hc0);
      chk({link.dp, link.dm}, 2'h0);
      wr(UTSC_OFS_IO0, 8'h00);
      chk({link.dp, link.dm}, 2'h2);
      sie_oe <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chk({link.dp_dev_oe, link.dm_dev_oe}, 2'h0);
   endtask
   task automatic t_activity();
      wr(UTSC_OFS_CR1, 8'h03);
      rd(UTSC_OFS_CR1, 8'h03, UTSC_RESP_OKAY);
      host(1'b1, 4);
      host(1'b0, 8);
      rd(UTSC_OFS_CR1, 8'h07, UTSC_RESP_OKAY);
      rd(UTSC_OFS_CR1, 8'h07, UTSC_RESP_OKAY);
      wr(UTSC_OFS_CR1, 8'h03);
      rd(UTSC_OFS_CR1, 8'h03, UTSC_RESP_OKAY);
      drive_se0 <= 1'b1;
      host(1'b1, 8);
      rd(UTSC_OFS_IO1, 8'h04, UTSC_RESP_OKAY);
      host(1'b0, 8);
      drive_se0 <= 1'b0;
      rd(UTSC_OFS_CR1, 8'h07, UTSC_RESP_OKAY);
   endtask
   task automatic t_sleep();
      int w0, e0;
      for (int i = 1; i < 4; i++)
      begin
         wake_int_enable <= 1'b0;
         wr(UTSC_OFS_CR1, 8'h03);
         w0 = wakes;
         e0 = eprs;
         nap(utsc_sleep_e'(i)); // nothing unretained to save here
         chk({asleep, regulator_low_power}, 2'h3);
         host(1'b1, 4);
         host(1'b0, 8);
         chk({asleep, 31'(wakes - w0)}, 32'h80000000);
         wake_int_enable <= 1'b1;
         host(1'b1, 6);
         host(1'b0, 8);
         chk(asleep, 1'h0);
         chk(wakes - w0, 1);
         chk(eprs - e0, i > 1);
         rd(UTSC_OFS_CR1, 8'h07, UTSC_RESP_OKAY);
         rd(UTSC_OFS_IO1, 8'h06, UTSC_RESP_OKAY);
      end
   endtask
   task automatic t_brief();
      int w0;
      wr(UTSC_OFS_IO1, 8'h00);
      repeat (6) @(posedge clk_sys);
      wr(UTSC_OFS_CR1, 8'h03);
      w0 = wakes;
      nap(UTSC_SLEEP_RETAIN);
      chk({asleep, 31'(wakes - w0)}, 32'h1);
   endtask
   initial
   begin
      repeat (2) @(posedge clk_sys);
      rst_b <= 1'b1;
      t_reset();
      t_ctrl();
      t_manual();
      t_activity();
      t_sleep();
      t_brief();
      wr(UTSC_OFS_CR0, 8'h00);
      chk({sie_rx_enable, rx_power_down}, 2'h1);
      end_of_test();
   end
endmodule
